// ===== hw/divider_path.sv
// One divider path: integer division, pulse width and coarse phase step.
// Assumes sys_clk_i is the selected fractional divider clock.
`timescale 1ns/1ps
module divider_path (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire clock_output_divider_pkg::ratio_t divide_ratio_i,
    input wire clock_output_divider_pkg::ratio_t high_count_i,
    input wire clock_output_divider_pkg::step_t step_value_i,
    input wire logic step_write_i,
    output logic clk_out_o,
    output logic step_pending_o
);
    import clock_output_divider_pkg::*;

    phase_e state_reg;
    len_t count_reg;
    len_t low_len_reg;
    step_t step_reg;
    logic pending_reg;

    len_t base_hi;
    len_t base_lo;
    len_t adj_hi;
    len_t adj_lo;
    len_t next_hi;
    len_t next_lo;

    function automatic len_t clamp_min(input len_t v);
        clamp_min = (v < MIN_INTERVAL) ? MIN_INTERVAL : v;
    endfunction : clamp_min

    // ------------------------------------------------------------------
    // Interval lengths for the coming period
    // ------------------------------------------------------------------
    always_comb begin
        if (high_count_i == '0) begin
            base_hi = len_t'({1'b0, divide_ratio_i[RATIO_W-1:1]}); // R04 R19
            base_lo = len_t'(divide_ratio_i) - base_hi; // R19
            adj_hi = len_t'(step_reg >>> 1); // R14
            adj_lo = len_t'(step_reg) - adj_hi; // R14
        end else begin
            base_hi = len_t'(high_count_i); // R05 R08
            base_lo = len_t'(divide_ratio_i) - len_t'(high_count_i); // R05
            adj_hi = LEN_ZERO; // R15
            adj_lo = len_t'(step_reg); // R15
        end
        if (pending_reg) begin
            // Whole step lands in this one period
            next_hi = (adj_hi == LEN_ZERO) ? base_hi : clamp_min(base_hi + adj_hi); // R09 R10 R13
            next_lo = clamp_min(base_lo + adj_lo); // R09 R10 R12 R13
        end else begin
            next_hi = base_hi; // R03
            next_lo = (base_lo < LEN_ONE) ? LEN_ONE : base_lo; // R03
        end
    end

    // ------------------------------------------------------------------
    // Period sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
            count_reg <= LEN_ZERO;
            low_len_reg <= LEN_ONE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= (next_hi > LEN_ZERO) ? ST_HIGH : ST_LOW;
                    count_reg <= (next_hi > LEN_ZERO) ? next_hi : next_lo;
                    low_len_reg <= next_lo;
                end
                ST_HIGH: begin
                    if (count_reg <= LEN_ONE) begin
                        state_reg <= ST_LOW;
                        count_reg <= low_len_reg;
                    end else begin
                        count_reg <= count_reg - LEN_ONE;
                    end
                end
                ST_LOW: begin
                    if (count_reg <= LEN_ONE) begin
                        // Period boundary: load next lengths
                        state_reg <= (next_hi > LEN_ZERO) ? ST_HIGH : ST_LOW; // R18
                        count_reg <= (next_hi > LEN_ZERO) ? next_hi : next_lo;
                        low_len_reg <= next_lo;
                    end else begin
                        count_reg <= count_reg - LEN_ONE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    count_reg <= LEN_ZERO;
                end
            endcase
        end
    end

    wire logic boundary = (state_reg == ST_IDLE)
        || ((state_reg == ST_LOW) && (count_reg <= LEN_ONE));

    // ------------------------------------------------------------------
    // Coarse step hold, consumed once at the boundary
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            step_reg <= STEP_ZERO;
            pending_reg <= 1'b0;
        end else if (step_write_i) begin
            step_reg <= step_value_i; // R18
            pending_reg <= 1'b1; // R18
        end else if (boundary) begin
            step_reg <= STEP_ZERO; // R18
            pending_reg <= 1'b0; // R18
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            clk_out_o <= 1'b0;
            step_pending_o <= 1'b0;
        end else begin
            clk_out_o <= (state_reg == ST_HIGH); // R07
            step_pending_o <= pending_reg;
        end
    end

endmodule : divider_path

// ===== hw/clock_output_divider_pkg.sv
// Constants shared by the output divider stage and its divider path.
// Assumes all config inputs are synchronous to the selected divider clock.
package clock_output_divider_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RATIO_W = 32;
    localparam int STEP_W = 34;
    localparam int LEN_W = 36;
    localparam int PATHS = 2;

    typedef logic [RATIO_W-1:0] ratio_t;
    typedef logic signed [STEP_W-1:0] step_t;
    typedef logic signed [LEN_W-1:0] len_t;

    // ------------------------------------------------------------------
    // Interval limits and reset values
    // ------------------------------------------------------------------
    localparam len_t MIN_INTERVAL = 36'sh0_0000_0002;
    localparam len_t LEN_ZERO = 36'sh0_0000_0000;
    localparam len_t LEN_ONE = 36'sh0_0000_0001;
    localparam step_t STEP_ZERO = 34'sh0_0000_0000;

    // ------------------------------------------------------------------
    // Stage numbers and divider sources
    // ------------------------------------------------------------------
    localparam logic [2:0] STAGE_FOUR = 3'h4;
    localparam logic [2:0] STAGE_FIVE = 3'h5;
    localparam logic [2:0] STAGE_SIX = 3'h6;
    localparam logic [2:0] STAGE_SEVEN = 3'h7;

    typedef enum logic [1:0] {
        SRC_DIV_FOUR = 2'h0,
        SRC_DIV_FIVE = 2'h1,
        SRC_DIV_SIX = 2'h2,
        SRC_DIV_SEVEN = 2'h3
    } source_e;

    // ------------------------------------------------------------------
    // Divider path states, Gray along idle, high, low
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HIGH = 2'b01,
        ST_LOW = 2'b11
    } phase_e;

endpackage : clock_output_divider_pkg

// ===== hw/clock_output_divider_stage.sv
// Output stage: source mapping, two divider paths and the pad pair of each.
// Assumes sys_clk_i is the divider clock chosen by the source select.
// Function
// R01 - Stage four uses divider four or five; five, six fixed; seven six or seven.
// R02 - Dual stage holds two identical paths fed by the same divider clock.
// R03 - Output divides the divider clock by a 32-bit unsigned ratio.
// R04 - Zero high count gives a 50/50 output.
// R05 - Nonzero high count sets high cycles per period; rest is low.
// R06 - Software keeps high count below the divide ratio.
// R07 - Shaped pulses are high going; invert complementary pad for low pulses.
// R08 - High pulse width works in every mode.
// R09 - Coarse step lengthens or shortens high and low intervals in input cycles.
// R10 - Adjusted period never below two high plus two low cycles; code leaves the high interval unclamped when its share of the step is zero.
// R11 - Software avoids coarse steps when the ratio is one to four.
// R12 - One step may change each interval by up to 2^32 cycles.
// R13 - Whole signed step applies in one period; positive lengthens.
// R14 - In 50/50 mode the step splits evenly over high and low.
// R15 - With a high count the step goes to the low interval only.
// R16 - Software may issue many steps, preferably small ones.
// R17 - Complementary pad copies the true pad, optionally inverted.
// R18 - Each step is consumed once at the next period boundary.
// R19 - Odd ratio in 50/50 mode: high is floor of half the ratio.
`timescale 1ns/1ps
module clock_output_divider_stage #(
    parameter logic [2:0] STAGE_NUMBER = 3'h4
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic stage4_source_select_i,
    input wire logic stage7_source_select_i,
    input wire clock_output_divider_pkg::ratio_t integer_divide_ratio_i [2],
    input wire clock_output_divider_pkg::ratio_t high_pulse_count_i [2],
    input wire clock_output_divider_pkg::step_t coarse_phase_step_i [2],
    input wire logic coarse_phase_step_write_i [2],
    input wire logic complementary_invert_i [2],
    output clock_output_divider_pkg::source_e active_source_o,
    output logic true_output_pad_o [2],
    output logic complementary_output_pad_o [2],
    output logic step_pending_o [2]
);
    import clock_output_divider_pkg::*;

    // ------------------------------------------------------------------
    // Source mapping
    // ------------------------------------------------------------------
    function automatic source_e map_source(input logic [2:0] stage, input logic sel4,
                                           input logic sel7);
        case (stage)
            STAGE_FOUR: map_source = sel4 ? SRC_DIV_FIVE : SRC_DIV_FOUR;
            STAGE_FIVE: map_source = SRC_DIV_FIVE;
            STAGE_SIX: map_source = SRC_DIV_SIX;
            STAGE_SEVEN: map_source = sel7 ? SRC_DIV_SEVEN : SRC_DIV_SIX;
            default: map_source = SRC_DIV_FOUR;
        endcase
    endfunction : map_source

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            active_source_o <= map_source(STAGE_NUMBER, 1'b0, 1'b0);
        end else begin
            active_source_o <= map_source(STAGE_NUMBER, stage4_source_select_i,
                                          stage7_source_select_i); // R01
        end
    end

    // ------------------------------------------------------------------
    // Two identical paths on one divider clock
    // ------------------------------------------------------------------
    logic path_clk [PATHS];
    logic path_pending [PATHS];

    for (genvar p = 0; p < PATHS; p++) begin : g_path // R02
        divider_path u_path (
            .sys_clk_i(sys_clk_i),
            .srst_i(srst_i),
            .divide_ratio_i(integer_divide_ratio_i[p]),
            .high_count_i(high_pulse_count_i[p]),
            .step_value_i(coarse_phase_step_i[p]),
            .step_write_i(coarse_phase_step_write_i[p]),
            .clk_out_o(path_clk[p]),
            .step_pending_o(path_pending[p])
        );

        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                true_output_pad_o[p] <= 1'b0;
                complementary_output_pad_o[p] <= 1'b0;
                step_pending_o[p] <= 1'b0;
            end else begin
                true_output_pad_o[p] <= path_clk[p];
                complementary_output_pad_o[p] <= path_clk[p] ^ complementary_invert_i[p]; // R17
                step_pending_o[p] <= path_pending[p];
            end
        end
    end

endmodule : clock_output_divider_stage

// ===== verif/clock_receiver_model.sv
// Downstream receiver model: measures high and low run lengths of one pad.
// Assumes the pad is sampled on the divider clock.
`timescale 1ns/1ps
module clock_receiver_model (
    input wire logic sys_clk_i,
    input wire logic pad_i,
    output int hi_len_o,
    output int lo_len_o,
    output int rises_o
);
    bit last_reg;
    int run_reg;
    always @(posedge sys_clk_i) begin
        last_reg <= pad_i;
        run_reg <= (pad_i != last_reg) ? 1 : run_reg + 1;
        if (pad_i && !last_reg) begin
            lo_len_o <= run_reg;
            rises_o <= rises_o + 1;
        end
        if (!pad_i && last_reg) begin
            hi_len_o <= run_reg;
        end
    end
endmodule : clock_receiver_model

// ===== verif/clock_output_divider_stage_properties.sv
// Checker on the stage ports: path 0 interval widths, pads, source, steps.
// Assumes the config inputs are held steady between resets.
`timescale 1ns/1ps
module clock_output_divider_stage_properties #(
    parameter logic [2:0] STAGE_NUMBER = 3'h4
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic stage4_source_select_i,
    input wire logic stage7_source_select_i,
    input wire clock_output_divider_pkg::ratio_t integer_divide_ratio_i [2],
    input wire clock_output_divider_pkg::ratio_t high_pulse_count_i [2],
    input wire clock_output_divider_pkg::step_t coarse_phase_step_i [2],
    input wire logic coarse_phase_step_write_i [2],
    input wire logic complementary_invert_i [2],
    input wire clock_output_divider_pkg::source_e active_source_o,
    input wire logic true_output_pad_o [2],
    input wire logic complementary_output_pad_o [2],
    input wire logic step_pending_o [2]
);
    import clock_output_divider_pkg::*;
    ratio_t run_reg;
    logic pad_reg;
    logic full_reg;
    logic stepped_reg;
    wire ratio_t ratio_w = integer_divide_ratio_i[0];
    wire ratio_t high_w = high_pulse_count_i[0];
    wire logic pad_w = true_output_pad_o[0];
    wire logic fall_w = pad_reg && !pad_w && full_reg;
    wire logic rise_w = !pad_reg && pad_w && full_reg;
    // Run length of the current pad level, and whether a step was seen
    always_ff @(posedge sys_clk_i) begin
        pad_reg <= !srst_i && pad_w;
        run_reg <= (srst_i || pad_w != pad_reg) ? 32'h1 : run_reg + 32'h1;
        full_reg <= !srst_i && (full_reg || (pad_reg && !pad_w));
        stepped_reg <= !srst_i && (stepped_reg || step_pending_o[0]
            || coarse_phase_step_write_i[0]);
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_pend_soon;
        ##[1:4] step_pending_o[0];
    endsequence
    sequence s_steady_fall;
        fall_w && !stepped_reg;
    endsequence
    AST_COMP_ZERO: assert property (!$past(srst_i) |->
        complementary_output_pad_o[0] == (pad_w ^ $past(complementary_invert_i[0])))
        else $error("complementary pad 0 mismatch");
    AST_COMP_ONE: assert property (!$past(srst_i) |->
        complementary_output_pad_o[1] ==
        (true_output_pad_o[1] ^ $past(complementary_invert_i[1])))
        else $error("complementary pad 1 mismatch");
    AST_SOURCE: assert property (STAGE_NUMBER == STAGE_FOUR && !$past(srst_i) &&
        $stable(stage4_source_select_i) |-> active_source_o ==
        (stage4_source_select_i ? SRC_DIV_FIVE : SRC_DIV_FOUR)) else $error("bad source");
    AST_SOURCE_SEVEN: assert property (STAGE_NUMBER == STAGE_SEVEN && !$past(srst_i) &&
        $stable(stage7_source_select_i) |-> active_source_o ==
        (stage7_source_select_i ? SRC_DIV_SEVEN : SRC_DIV_SIX)) else $error("bad source seven");
    AST_STEP_PEND: assert property (coarse_phase_step_write_i[0] |-> s_pend_soon)
        else $error("step not pending");
    AST_HI_PULSE: assert property (fall_w && high_w != '0 |-> run_reg == high_w)
        else $error("pulse high width wrong");
    AST_LO_PULSE: assert property (rise_w && high_w != '0 && !stepped_reg |->
        run_reg == ratio_w - high_w) else $error("pulse low width wrong");
    AST_HI_HALF: assert property (s_steady_fall ##0 high_w == '0 |->
        run_reg == ratio_w >> 1) else $error("half high width wrong");
    AST_LO_HALF: assert property (rise_w && high_w == '0 && !stepped_reg |->
        run_reg == ratio_w - (ratio_w >> 1)) else $error("half low width wrong");
endmodule : clock_output_divider_stage_properties

bind clock_output_divider_stage clock_output_divider_stage_properties #(
    .STAGE_NUMBER(STAGE_NUMBER)) u_props (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .stage4_source_select_i(stage4_source_select_i),
    .stage7_source_select_i(stage7_source_select_i),
    .integer_divide_ratio_i(integer_divide_ratio_i), .high_pulse_count_i(high_pulse_count_i),
    .coarse_phase_step_i(coarse_phase_step_i),
    .coarse_phase_step_write_i(coarse_phase_step_write_i),
    .complementary_invert_i(complementary_invert_i), .active_source_o(active_source_o),
    .true_output_pad_o(true_output_pad_o),
    .complementary_output_pad_o(complementary_output_pad_o),
    .step_pending_o(step_pending_o));

// ===== verif/clock_output_divider_stage_test.sv
// Self-checking bench: interval widths, coarse steps, pads, source mapping.
// Assumes a receiver model measures each true pad.
`timescale 1ns/1ps
module clock_output_divider_stage_test;
    import clock_output_divider_pkg::*;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic sel4 = 1'b0;
    logic sel7 = 1'b0;
    ratio_t ratio [2] = '{default: 32'ha};
    ratio_t high [2] = '{default: 32'h0};
    step_t step [2] = '{default: 34'sh0};
    logic wr [2] = '{default: 1'b0};
    logic inv [2] = '{1'b0, 1'b1};
    source_e src;
    source_e src_seven;
    logic tpad [2];
    logic cpad [2];
    logic pend [2];
    int hi [2];
    int lo [2];
    int rises [2];
    int num_errors = 0;
    int num_checks = 0;
    clock_output_divider_stage #(.STAGE_NUMBER(STAGE_FOUR)) uut (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .stage4_source_select_i(sel4), .stage7_source_select_i(sel7),
        .integer_divide_ratio_i(ratio), .high_pulse_count_i(high), .coarse_phase_step_i(step),
        .coarse_phase_step_write_i(wr), .complementary_invert_i(inv), .active_source_o(src),
        .true_output_pad_o(tpad), .complementary_output_pad_o(cpad), .step_pending_o(pend));
    // Stage seven copy, only its source mapping is judged here
    clock_output_divider_stage #(.STAGE_NUMBER(STAGE_SEVEN)) uut_seven (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .stage4_source_select_i(sel4), .stage7_source_select_i(sel7),
        .integer_divide_ratio_i(ratio), .high_pulse_count_i(high), .coarse_phase_step_i(step),
        .coarse_phase_step_write_i(wr), .complementary_invert_i(inv),
        .active_source_o(src_seven), .true_output_pad_o(), .complementary_output_pad_o(),
        .step_pending_o());
    for (genvar i = 0; i < PATHS; i++) begin : g_rx
        clock_receiver_model rx (.sys_clk_i(sys_clk_i), .pad_i(tpad[i]), .hi_len_o(hi[i]),
            .lo_len_o(lo[i]), .rises_o(rises[i]));
    end
    initial forever #20 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_rises(input int n);
        int target = rises[0] + n;
        for (int c = 0; c < 4000 && rises[0] < target; c++) begin
            @(posedge sys_clk_i);
            #1;
        end
        check(rises[0] >= target, 1'b1);
    endtask : wait_rises
    task automatic restart(input ratio_t r, input ratio_t h);
        @(posedge sys_clk_i);
        ratio <= '{r, r + 32'h2};
        high <= '{h, 32'h0};
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        wait_rises(4);
    endtask : restart
    task automatic t_shape(input ratio_t r, input ratio_t h);
        restart(r, h);
        check(hi[0], h == 0 ? r >> 1 : h);
        check(lo[0], h == 0 ? r - (r >> 1) : r - h);
        check(hi[1], (r + 2) >> 1);
        check(lo[1], (r + 2) - ((r + 2) >> 1));
        check(cpad[1], !tpad[1]);
        check(cpad[0], tpad[0]);
        $display("shape test done");
    endtask : t_shape
    task automatic t_step(input ratio_t h, input step_t s, input int ehi, input int elo);
        restart(32'ha, h);
        @(posedge sys_clk_i);
        step[0] <= 34'sh100;
        wr[0] <= 1'b1;
        @(posedge sys_clk_i);
        step[0] <= s;
        @(posedge sys_clk_i);
        wr[0] <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        check(pend[0], 1'b1);
        wait_rises(2);
        check(hi[0], ehi);
        check(lo[0], elo);
        check(pend[0], 1'b0);
        wait_rises(1);
        check(hi[0], h == 0 ? 5 : h);
        check(lo[0], 10 - (h == 0 ? 5 : h));
        $display("step test done");
    endtask : t_step
    task automatic t_source();
        @(posedge sys_clk_i);
        sel4 <= 1'b1;
        sel7 <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        check(src, SRC_DIV_FIVE);
        check(src_seven, SRC_DIV_SEVEN);
        @(posedge sys_clk_i);
        sel4 <= 1'b0;
        sel7 <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        #1;
        check(src, SRC_DIV_FOUR);
        check(src_seven, SRC_DIV_SIX);
        $display("source test done");
    endtask : t_source
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        #2000000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        t_source();
        t_shape(32'ha, 32'h0);
        t_shape(32'h9, 32'h0);
        t_shape(32'ha, 32'h3);
        t_shape(32'h9, 32'h1);
        t_shape(32'hc, 32'hb);
        t_step(32'h0, 34'sh4, 7, 7);
        t_step(32'h0, 34'sh3, 6, 7);
        t_step(32'h0, -34'sh14, 2, 2);
        t_step(32'h3, 34'sh5, 3, 12);
        t_step(32'h3, -34'sh14, 3, 2);
        complete_run();
    end
endmodule : clock_output_divider_stage_test
